// *** hw/cpd_pkg.sv ***
package cpd_pkg;
   localparam int SLOTS = 8;
   localparam int WORD = 32;
   localparam int IDXW = 4;
   localparam int FIFO_DEPTH = 8;
   localparam logic [7:0] MAP_OBJECT = 8'h11;
   localparam logic [5:0] SUB_TX_FIRST = 6'h10;
   localparam logic [5:0] SUB_RX_FIRST = 6'h18;
   localparam logic [5:0] SUB_LAST = 6'h1F;
   localparam logic [31:0] REG_NONE = 32'h0000_0000;
   localparam logic [31:0] REG_STATUS = 32'h0000_0023;
   localparam logic [31:0] MOTOR_REG_MAX = 32'h0000_FFFF;
   localparam logic [31:0] MODULE_REG_STEP = 32'h0001_0000;

   typedef logic [SLOTS-1:0][WORD-1:0] cpd_map_t;

   // Slot 0 is the lowest element.
   localparam cpd_map_t DEF_TX = {32'h0, 32'h0, 32'h0, 32'h0000_0023,
      32'h0000_00A9, 32'h0000_000C, 32'h0000_000A, 32'h0000_0002};
   localparam cpd_map_t DEF_RX = {32'h0, 32'h0, 32'h0, 32'h0,
      32'h0000_0007, 32'h0000_0005, 32'h0000_0003, 32'h0000_0002};

   typedef enum logic [1:0] {
      CPD_BOOT = 2'b00,
      CPD_IDLE = 2'b01,
      CPD_READ = 2'b10
   } cpd_state_t;

   function automatic logic cpd_is_module(input logic [31:0] num);
      return num > MOTOR_REG_MAX;
   endfunction : cpd_is_module

   function automatic logic [31:0] cpd_module_num(input logic [5:0] sub);
      return MODULE_REG_STEP * {26'h0, sub};
   endfunction : cpd_module_num

   // Number of slots in use: the list ends at the first empty slot.
   function automatic logic [IDXW-1:0] cpd_list_len(input cpd_map_t m);
      logic ended;
      logic [IDXW-1:0] n;
      ended = 1'b0;
      n = '0;
      for (int i = 0; i < SLOTS; i++) begin
         if (m[i] == REG_NONE) ended = 1'b1;
         if (!ended) n = n + 4'h1;
      end
      return n;
   endfunction : cpd_list_len

   // Puts the status register into the read list when it is missing.
   // It goes in front of the first empty or module slot, so module
   // registers stay behind the motor registers; a full list loses its
   // last slot.
   function automatic cpd_map_t cpd_force_status(input cpd_map_t m);
      logic ended;
      logic found;
      logic [IDXW-1:0] pos;
      cpd_map_t r;
      ended = 1'b0;
      found = 1'b0;
      pos = 4'(SLOTS);
      for (int i = 0; i < SLOTS; i++) begin
         if (m[i] == REG_NONE) ended = 1'b1;
         if (!ended && m[i] == REG_STATUS) found = 1'b1;
         if (pos == 4'(SLOTS) && (m[i] == REG_NONE || cpd_is_module(m[i])))
            pos = 4'(i);
      end
      if (pos == 4'(SLOTS)) pos = 4'(SLOTS - 1);
      r = m;
      if (!found) begin
         for (int i = 1; i < SLOTS; i++) begin
            if (4'(i) > pos) r[i] = m[i-1];
         end
         r[pos[2:0]] = REG_STATUS;
      end
      return r;
   endfunction : cpd_force_status
endpackage : cpd_pkg

// *** hw/cpd_fifo.sv ***
`timescale 1ns/10ps
module cpd_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] mem_next [DEPTH];
   logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
   logic full, empty;

   assign empty = wr_reg == rd_reg;
   assign full = (wr_reg[AW] != rd_reg[AW])
      && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_reg[rd_reg[AW-1:0]];

   always_comb begin
      mem_next = mem_reg;
      wr_next = wr_reg;
      rd_next = rd_reg;
      if (in_valid && !full) begin
         mem_next[wr_reg[AW-1:0]] = in_data;
         wr_next = wr_reg + 1'b1;
      end
      if (out_ready && !empty) rd_next = rd_reg + 1'b1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         mem_reg <= mem_next;
      end
   end
endmodule : cpd_fifo

// *** hw/cpd_mapper.sv ***
// How it works
// - Each cycle moves read words to the master and written words inward.
// - Eight slots each way, every slot one 32-bit register value.
// - Parameter object 0x11 subindexes 16 to 31 set slot register numbers.
// - New mapping is used only after save and a power cycle.
// - Default read slots: 2, 10, 12, 169, 35; slots 5 to 7 empty.
// - Default write slots: 2, 3, 5, 7; slots 4 to 7 empty.
// - Status register 35 is always inserted into the read list.
// - Module register number is 65536 times its module subindex.
// - A zero slot ends the list; it and later slots are ignored.
// - Cycles requested too fast may be dropped by the device.
// - Module registers appended last are read each cycle like any other slot.
// - Subindexes 16-20 are read positions 1-5, 24-28 write positions 1-5.
// - Mapping reaches storage only on an explicit save command.
`timescale 1ns/10ps
module cpd_mapper
   import cpd_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_obj,
   input wire logic [5:0] cfg_sub,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   input wire logic cfg_save,
   output logic flash_save,
   output logic [2*SLOTS*WORD-1:0] flash_image,
   input wire logic flash_map_valid,
   input wire logic [2*SLOTS*WORD-1:0] flash_map,
   input wire logic cyc_start,
   output logic cyc_overrun,
   output logic reg_rd_req,
   output logic [31:0] reg_rd_num,
   input wire logic reg_rd_ack,
   input wire logic [31:0] reg_rd_data,
   output logic reg_wr,
   output logic [31:0] reg_wr_num,
   output logic [31:0] reg_wr_data,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic rx_first,
   input wire logic [31:0] rx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [31:0] tx_data,
   output logic [IDXW-1:0] tx_len,
   output logic [IDXW-1:0] rx_len
);
   cpd_state_t state_reg, state_next;
   cpd_map_t act_tx_reg, act_tx_next, act_rx_reg, act_rx_next;
   cpd_map_t stg_tx_reg, stg_tx_next, stg_rx_reg, stg_rx_next;
   logic [IDXW-1:0] tx_len_reg, tx_len_next, rx_len_reg, rx_len_next;
   logic [IDXW-1:0] tx_idx_reg, tx_idx_next, rx_idx_reg, rx_idx_next;
   logic [31:0] cfg_rdata_reg, cfg_rdata_next;
   logic flash_save_reg, flash_save_next, overrun_reg, overrun_next;
   logic wr_reg, wr_next;
   logic [31:0] wr_num_reg, wr_num_next, wr_data_reg, wr_data_next;
   logic fifo_in_ready, push, cfg_hit, cfg_is_rx, status_present;
   logic [2:0] cfg_slot;
   logic [IDXW-1:0] rx_word;
   cpd_map_t boot_tx, boot_rx;

   assign cfg_hit = cfg_obj == MAP_OBJECT && cfg_sub >= SUB_TX_FIRST
      && cfg_sub <= SUB_LAST;
   assign cfg_is_rx = cfg_sub >= SUB_RX_FIRST;
   assign cfg_slot = cfg_sub[2:0];
   assign rx_word = rx_first ? '0 : rx_idx_reg;
   assign reg_rd_req = state_reg == CPD_READ && fifo_in_ready;
   assign reg_rd_num = act_tx_reg[tx_idx_reg[2:0]];
   assign push = reg_rd_req && reg_rd_ack;
   assign rx_ready = state_reg != CPD_BOOT;

   // Flash image: words 0-7 are read slots, words 8-15 are write slots.
   assign boot_tx = flash_map_valid ? flash_map[SLOTS*WORD-1:0] : DEF_TX;
   assign boot_rx = flash_map_valid ? flash_map[2*SLOTS*WORD-1:SLOTS*WORD]
      : DEF_RX;

   always_comb begin
      state_next = state_reg;
      act_tx_next = act_tx_reg;
      act_rx_next = act_rx_reg;
      tx_len_next = tx_len_reg;
      rx_len_next = rx_len_reg;
      stg_tx_next = stg_tx_reg;
      stg_rx_next = stg_rx_reg;
      tx_idx_next = tx_idx_reg;
      overrun_next = 1'b0;
      unique case (state_reg)
         CPD_BOOT: begin
            // The working map is captured once, after reset release.
            act_tx_next = cpd_force_status(boot_tx);
            act_rx_next = boot_rx;
            tx_len_next = cpd_list_len(cpd_force_status(boot_tx));
            rx_len_next = cpd_list_len(boot_rx);
            stg_tx_next = boot_tx;
            stg_rx_next = boot_rx;
            state_next = CPD_IDLE;
         end
         CPD_IDLE: begin
            if (cyc_start) begin
               tx_idx_next = '0;
               state_next = CPD_READ;
            end
         end
         CPD_READ: begin
            if (cyc_start) overrun_next = 1'b1;
            if (push) begin
               tx_idx_next = tx_idx_reg + 4'h1;
               if (tx_idx_reg == tx_len_reg - 4'h1)
                  state_next = CPD_IDLE;
            end
         end
         default: state_next = CPD_BOOT;
      endcase
      // Writes land in the staged map only; the working map stays.
      if (cfg_wr && cfg_hit && state_reg != CPD_BOOT) begin
         if (cfg_is_rx) stg_rx_next[cfg_slot] = cfg_wdata;
         else stg_tx_next[cfg_slot] = cfg_wdata;
      end
   end

   always_comb begin
      cfg_rdata_next = cfg_rdata_reg;
      if (cfg_hit) cfg_rdata_next = cfg_is_rx ? stg_rx_reg[cfg_slot]
         : stg_tx_reg[cfg_slot];
      flash_save_next = cfg_save && state_reg != CPD_BOOT;
      rx_idx_next = rx_idx_reg;
      wr_next = 1'b0;
      wr_num_next = wr_num_reg;
      wr_data_next = wr_data_reg;
      if (rx_valid && rx_ready) begin
         if (rx_word < 4'(SLOTS)) rx_idx_next = rx_word + 4'h1;
         if (rx_word < rx_len_reg) begin
            wr_next = 1'b1;
            wr_num_next = act_rx_reg[rx_word[2:0]];
            wr_data_next = rx_data;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= CPD_BOOT;
         act_tx_reg <= DEF_TX;
         act_rx_reg <= DEF_RX;
         stg_tx_reg <= DEF_TX;
         stg_rx_reg <= DEF_RX;
         tx_len_reg <= '0;
         rx_len_reg <= '0;
         tx_idx_reg <= '0;
         rx_idx_reg <= '0;
         cfg_rdata_reg <= '0;
         flash_save_reg <= 1'b0;
         overrun_reg <= 1'b0;
         wr_reg <= 1'b0;
         wr_num_reg <= '0;
         wr_data_reg <= '0;
      end else begin
         state_reg <= state_next;
         act_tx_reg <= act_tx_next;
         act_rx_reg <= act_rx_next;
         stg_tx_reg <= stg_tx_next;
         stg_rx_reg <= stg_rx_next;
         tx_len_reg <= tx_len_next;
         rx_len_reg <= rx_len_next;
         tx_idx_reg <= tx_idx_next;
         rx_idx_reg <= rx_idx_next;
         cfg_rdata_reg <= cfg_rdata_next;
         flash_save_reg <= flash_save_next;
         overrun_reg <= overrun_next;
         wr_reg <= wr_next;
         wr_num_reg <= wr_num_next;
         wr_data_reg <= wr_data_next;
      end
   end

   // Read values queue here in slot order; a stalled master stops reads.
   cpd_fifo #(.WIDTH(WORD), .DEPTH(DEPTH)) u_tx_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(reg_rd_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(tx_data)
   );

   assign cfg_rdata = cfg_rdata_reg;
   assign flash_save = flash_save_reg;
   assign flash_image = {stg_rx_reg, stg_tx_reg};
   assign cyc_overrun = overrun_reg;
   assign reg_wr = wr_reg;
   assign reg_wr_num = wr_num_reg;
   assign reg_wr_data = wr_data_reg;
   assign tx_len = tx_len_reg;
   assign rx_len = rx_len_reg;

   always_comb begin
      status_present = 1'b0;
      for (int i = 0; i < SLOTS; i++) begin
         if (4'(i) < tx_len_reg && act_tx_reg[i] == REG_STATUS)
            status_present = 1'b1;
      end
   end

   a_status_listed: assert property (@(posedge sys_clk) disable iff (rst)
      state_reg != CPD_BOOT |-> status_present)
      else $error("status register missing from read list");
   a_read_order: assert property (@(posedge sys_clk) disable iff (rst)
      push && state_next == CPD_READ
      |=> tx_idx_reg == $past(tx_idx_reg) + 4'h1)
      else $error("read slots not taken in ascending order");
   a_list_end: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd_req |-> tx_idx_reg < tx_len_reg && reg_rd_num != REG_NONE)
      else $error("slot beyond list end was read");
   a_wr_first: assert property (@(posedge sys_clk) disable iff (rst)
      rx_valid && rx_ready && rx_first && rx_len_reg != 4'h0
      |=> reg_wr && reg_wr_num == act_rx_reg[0]
      && reg_wr_data == $past(rx_data))
      else $error("first write word not sent to slot 0 register");
   a_save_only: assert property (@(posedge sys_clk) disable iff (rst)
      flash_save |-> $past(cfg_save))
      else $error("storage written without save command");
   a_map_hold: assert property (@(posedge sys_clk) disable iff (rst)
      state_reg != CPD_BOOT |=> $stable(act_tx_reg) && $stable(act_rx_reg))
      else $error("working map changed without power cycle");
   a_overrun_flag: assert property (@(posedge sys_clk) disable iff (rst)
      state_reg == CPD_READ && cyc_start |=> cyc_overrun ##1 !cyc_overrun)
      else $error("early cycle request not flagged");
   a_default_map: assert property (@(posedge sys_clk) disable iff (rst)
      state_reg == CPD_BOOT && !flash_map_valid
      |=> act_tx_reg == DEF_TX && act_rx_reg == DEF_RX && tx_len_reg == 4'h5)
      else $error("default map not applied");
   a_cfg_store: assert property (@(posedge sys_clk) disable iff (rst)
      cfg_wr && cfg_hit && !cfg_is_rx && state_reg != CPD_BOOT
      |=> stg_tx_reg[$past(cfg_slot)] == $past(cfg_wdata))
      else $error("mapping write not stored");
endmodule : cpd_mapper

// *** tb/cpd_motor_model.sv ***
`timescale 1ns/10ps
module cpd_motor_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] delay,
   input wire logic reg_rd_req,
   input wire logic [31:0] reg_rd_num,
   output logic reg_rd_ack,
   output logic [31:0] reg_rd_data
);
   logic [3:0] wait_reg;
   // Between answers the data lines flip every cycle so that a stale
   // word is never mistaken for a fresh one.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rd_ack <= 1'b0;
         reg_rd_data <= 32'h0;
         wait_reg <= 4'h0;
      end else if (reg_rd_req && !reg_rd_ack && wait_reg >= delay) begin
         reg_rd_ack <= 1'b1;
         reg_rd_data <= {reg_rd_num[15:0], ~reg_rd_num[15:0]};
         wait_reg <= 4'h0;
      end else begin
         reg_rd_ack <= 1'b0;
         reg_rd_data <= ~reg_rd_data;
         wait_reg <= reg_rd_req ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule : cpd_motor_model

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   import cpd_pkg::*;
   logic sys_clk = 1'b0, rst = 1'b1, cfg_wr = 1'b0, cfg_save = 1'b0;
   logic [7:0] cfg_obj = 8'h0;
   logic [5:0] cfg_sub = 6'h0;
   logic [31:0] cfg_wdata = 32'h0, rx_data = 32'h0;
   logic [31:0] cfg_rdata, reg_rd_num, reg_rd_data, reg_wr_num;
   logic [31:0] reg_wr_data, tx_data;
   logic [511:0] flash_image, img, flash_map = '0;
   logic flash_map_valid = 1'b0, cyc_start = 1'b0, rx_valid = 1'b0;
   logic rx_first = 1'b0, tx_ready = 1'b0, flash_save, cyc_overrun;
   logic reg_rd_req, reg_rd_ack, reg_wr, rx_ready, tx_valid;
   logic [3:0] tx_len, rx_len, delay = 4'h0;
   logic [31:0] rdq[$], txq[$], wrq[$], wdq[$], nm[16];
   int seed = 32'h1193;
   int n_errors = 0, checks_done = 0, n_ovr = 0;

   always #4 sys_clk = ~sys_clk;

   cpd_mapper #(.DEPTH(FIFO_DEPTH)) u_dut (.sys_clk(sys_clk), .rst(rst),
      .cfg_wr(cfg_wr), .cfg_obj(cfg_obj), .cfg_sub(cfg_sub),
      .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_save(cfg_save),
      .flash_save(flash_save), .flash_image(flash_image),
      .flash_map_valid(flash_map_valid), .flash_map(flash_map),
      .cyc_start(cyc_start), .cyc_overrun(cyc_overrun),
      .reg_rd_req(reg_rd_req), .reg_rd_num(reg_rd_num),
      .reg_rd_ack(reg_rd_ack), .reg_rd_data(reg_rd_data),
      .reg_wr(reg_wr), .reg_wr_num(reg_wr_num),
      .reg_wr_data(reg_wr_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_first(rx_first), .rx_data(rx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .tx_len(tx_len), .rx_len(rx_len));

   cpd_motor_model u_motor (.sys_clk(sys_clk), .rst(rst), .delay(delay),
      .reg_rd_req(reg_rd_req), .reg_rd_num(reg_rd_num),
      .reg_rd_ack(reg_rd_ack), .reg_rd_data(reg_rd_data));

   // The far side stalls the read stream at random.
   always @(posedge sys_clk) begin
      if (reg_rd_req && reg_rd_ack) rdq.push_back(reg_rd_num);
      if (tx_valid && tx_ready) txq.push_back(tx_data);
      if (reg_wr) wrq.push_back(reg_wr_num);
      if (reg_wr) wdq.push_back(reg_wr_data);
      if (cyc_overrun) n_ovr++;
      if (flash_save) img = flash_image;
      tx_ready <= ($random(seed) % 4) != 0;
   end

   function automatic logic [31:0] val(input logic [31:0] n);
      return {n[15:0], ~n[15:0]};
   endfunction : val

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task print_verdict;
      $display("counts checks=%0d errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   task boot(input logic v);
      rst <= 1'b1;
      flash_map_valid <= v;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask : boot

   task run_cycle(input logic [31:0] e[8], input int n, input logic ovr);
      int k;
      rdq.delete();
      txq.delete();
      n_ovr = 0;
      @(posedge sys_clk);
      cyc_start <= 1'b1;
      @(posedge sys_clk);
      cyc_start <= 1'b0;
      @(posedge sys_clk);
      cyc_start <= ovr;
      @(posedge sys_clk);
      cyc_start <= 1'b0;
      k = 0;
      while (txq.size() < n && k < 500) begin
         @(posedge sys_clk);
         k++;
      end
      repeat (20) @(posedge sys_clk);
      chk(rdq.size(), n);
      chk(txq.size(), n);
      for (int i = 0; i < n; i++) begin
         chk(rdq[i], e[i]);
         chk(txq[i], val(e[i]));
      end
      chk(n_ovr, ovr);
   endtask : run_cycle

   task send_rx(input int n, input int ne, input logic [31:0] e[8]);
      logic [31:0] w;
      logic [31:0] d[$];
      wrq.delete();
      wdq.delete();
      d.delete();
      @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         w = $random(seed);
         d.push_back(w);
         rx_valid <= 1'b1;
         rx_first <= (i == 0);
         rx_data <= w;
         do @(posedge sys_clk); while (!rx_ready);
      end
      rx_valid <= 1'b0;
      repeat (5) @(posedge sys_clk);
      chk(wrq.size(), ne);
      for (int i = 0; i < ne; i++) begin
         chk(wrq[i], e[i]);
         chk(wdq[i], d[i]);
      end
   endtask : send_rx

   task cfg(input logic [7:0] o, input logic [5:0] s, input logic [31:0] v);
      @(posedge sys_clk);
      cfg_wr <= 1'b1;
      cfg_obj <= o;
      cfg_sub <= s;
      cfg_wdata <= v;
      @(posedge sys_clk);
      cfg_wr <= 1'b0;
   endtask : cfg

   initial begin
      #200000;
      n_errors++;
      print_verdict();
   end

   initial begin
      nm = '{32'hA, 32'h000F_0000, 0, 32'h44, 32'h55, 0, 0, 0,
         32'h3, 32'h5, 0, 32'h9, 0, 0, 0, 0};
      boot(1'b0);
      chk(tx_len, 5);
      chk(rx_len, 4);
      run_cycle('{2, 10, 12, 169, 35, 0, 0, 0}, 5, 1'b1);
      send_rx(5, 4, '{2, 3, 5, 7, 0, 0, 0, 0});
      $display("test default map done");
      delay <= 4'h3;
      run_cycle('{2, 10, 12, 169, 35, 0, 0, 0}, 5, 1'b0);
      $display("test slow partner done");
      for (int i = 0; i < 16; i++) cfg(MAP_OBJECT, 6'h10 + 6'(i), nm[i]);
      cfg(8'h12, 6'h10, 32'hBAD);
      cfg(MAP_OBJECT, 6'h0F, 32'hBAD);
      cfg_sub <= 6'h19;
      repeat (3) @(posedge sys_clk);
      chk(cfg_rdata, nm[9]);
      chk(tx_len, 5);
      run_cycle('{2, 10, 12, 169, 35, 0, 0, 0}, 5, 1'b0);
      cfg_save <= 1'b1;
      @(posedge sys_clk);
      cfg_save <= 1'b0;
      repeat (3) @(posedge sys_clk);
      for (int i = 0; i < 16; i++) chk(img[i*32 +: 32], nm[i]);
      $display("test staging and save done");
      flash_map <= img;
      delay <= 4'h1;
      boot(1'b1);
      chk(tx_len, 3);
      chk(rx_len, 2);
      run_cycle('{10, 35, 32'h000F_0000, 0, 0, 0, 0, 0}, 3, 1'b0);
      send_rx(3, 2, '{3, 5, 0, 0, 0, 0, 0, 0});
      $display("test saved map done");
      print_verdict();
   end
endmodule : testbench
